// File: logic/wide_port.sv
// Eight-bit port and three-pin control port with parallel slave mode, registers on AHB-Lite.
// Assumes pins arrive asynchronously; tristate wires are resolved outside from the enables.
//
// Contract
// - Each of the eight wide port pins is an input or output by its own direction bit.
// - Setting bit 4 of the control direction register turns the wide port into a parallel slave port.
// - Each of the three control pins is an input or output by its own direction bit.
// - In slave mode the control pins act as read, write and select strobes.
// - A control pin selected as analog reads as zero.
// - The control direction bits still steer the pins while analog.
// - After reset the control pins are analog and read zero.
// - The wide port direction register resets to all ones.
// - The control direction register resets to 0x07 with bit 3 reading zero.
// - On variants without the ports their registers read zero and ignore writes.
// - In slave mode a read with select low drives the data register onto the pins.
// - In slave mode a write with select low latches the pins into the data register.
`timescale 1ns/10ps
`default_nettype none
module wide_port
  import wide_port_pkg::*;
#(
  parameter bit PORTS_PRESENT = 1'b1
) (
  input wire logic core_clk, // Core clock, 10 MHz.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic hsel, // AHB slave select.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write.
  input wire logic [2:0] hsize, // AHB size.
  input wire logic [31:0] hwdata, // AHB write data.
  input wire logic hready, // AHB bus ready.
  output logic [31:0] hrdata, // AHB read data.
  output logic hreadyout, // AHB slave ready.
  output logic hresp, // AHB response, always OKAY.
  input wire logic [7:0] widePinIn, // Wide port pin levels.
  output logic [7:0] widePinOut, // Wide port drive values.
  output logic [7:0] widePinOe_b, // Wide port enable, low drives.
  input wire logic [2:0] ctrlPinIn, // Control pin levels.
  output logic [2:0] ctrlPinOut, // Control pin drive values.
  output logic [2:0] ctrlPinOe_b // Control pin enable, low drives.
);
  logic [7:0] widePins_q, widePins_d;
  logic [7:0] wideDir_q, wideDir_d;
  logic [7:0] ctrlDir_q, ctrlDir_d;
  logic [2:0] ctrlPins_q, ctrlPins_d;
  logic [2:0] analogSel_q, analogSel_d;
  logic [7:0] wideSync;
  logic [2:0] ctrlSync;
  logic wrPend_q;
  logic [7:0] wrIdx_q;
  logic [31:0] hrdata_d;
  logic writeStrobePrev_q;

  // Pins pass two flops before any logic reads them.
  pin_sync #(.W(8)) u_wide_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn(widePinIn),
    .pinSync(wideSync)
  );
  pin_sync #(.W(3)) u_ctrl_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn(ctrlPinIn),
    .pinSync(ctrlSync)
  );

  // Bus decode; only word transfers inside the index range are honoured.
  wire addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == HSIZE_WORD);
  wire [7:0] reqIdx = haddr[9:2];
  wire inRange = (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'h0);
  wire wrTake = addrPhase & hwrite & inRange;
  wire rdTake = addrPhase & ~hwrite & inRange;

  // Slave-mode decode of the synchronised strobes, active low.
  wire slaveMode = ctrlDir_q[SLAVE_SEL_BIT];
  wire selActive = slaveMode & ~ctrlSync[STB_SELECT];
  wire readActive = selActive & ~ctrlSync[STB_READ];
  wire writeActive = selActive & ~ctrlSync[STB_WRITE];
  wire extWrite = writeActive & ~writeStrobePrev_q;

  // Pin read views: analog control pins read zero.
  // They use the values as they stand after this edge, so a read right behind a write sees the new value.
  wire [2:0] ctrlRead = ctrlSync & ~analogSel_d;
  wire wideSlaveNext = ctrlDir_d[SLAVE_SEL_BIT];
  wire [7:0] wideRead = wideSlaveNext ? widePins_d : gpioView(wideSync, widePins_d, wideDir_d);

  // Read data selection; absent ports read zero.
  always_comb begin
    hrdata_d = 32'h0;
    if (PORTS_PRESENT) begin
      unique case (reqIdx)
        IDX_WIDE_PINS: hrdata_d = {24'h0, wideRead};
        IDX_WIDE_DIR: hrdata_d = {24'h0, wideDir_d};
        IDX_CTRL_DIR: hrdata_d = {24'h0, ctrlDir_d & CTRL_DIR_MASK};
        IDX_CTRL_PINS: hrdata_d = {29'h0, ctrlRead};
        IDX_ANALOG_CFG: hrdata_d = {29'h0, analogSel_d};
        default: hrdata_d = 32'h0;
      endcase
    end
  end

  // Register next values: bus write, then slave-port latch which wins.
  always_comb begin
    widePins_d = widePins_q;
    wideDir_d = wideDir_q;
    ctrlDir_d = ctrlDir_q;
    ctrlPins_d = ctrlPins_q;
    analogSel_d = analogSel_q;
    if (wrPend_q && PORTS_PRESENT) begin
      unique case (wrIdx_q)
        IDX_WIDE_PINS: widePins_d = hwdata[7:0];
        IDX_WIDE_DIR: wideDir_d = hwdata[7:0];
        IDX_CTRL_DIR: ctrlDir_d = {ctrlDir_q[7:5], hwdata[4], 1'b0, hwdata[2:0]};
        IDX_CTRL_PINS: ctrlPins_d = hwdata[2:0];
        IDX_ANALOG_CFG: analogSel_d = hwdata[2:0];
        default: widePins_d = widePins_q;
      endcase
    end
    if (extWrite) begin
      widePins_d = wideSync;
    end
  end

  // Bus phase tracking; the slave never inserts wait states.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_q <= 1'b0;
      wrIdx_q <= 8'h0;
    end else begin
      wrPend_q <= wrTake;
      wrIdx_q <= reqIdx;
    end
  end

  // Register state with documented reset values.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      widePins_q <= WIDE_PINS_RESET;
      wideDir_q <= WIDE_DIR_RESET;
      ctrlDir_q <= CTRL_DIR_RESET;
      ctrlPins_q <= 3'h0;
      analogSel_q <= ANALOG_RESET;
      writeStrobePrev_q <= 1'b0;
    end else begin
      widePins_q <= widePins_d;
      wideDir_q <= wideDir_d;
      ctrlDir_q <= ctrlDir_d;
      ctrlPins_q <= ctrlPins_d;
      analogSel_q <= analogSel_d;
      writeStrobePrev_q <= writeActive;
    end
  end

  // Read data is registered at the edge that takes the address phase, so it stands through the data phase.
  // Registering it one cycle later would hand the master stale data at the edge where it samples.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= hrdata_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Pin drivers: slave mode drives the data byte only during a selected read.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      widePinOut <= 8'h0;
      widePinOe_b <= 8'hff;
      ctrlPinOut <= 3'h0;
      ctrlPinOe_b <= 3'h7;
    end else begin
      widePinOut <= widePins_d;
      if (!PORTS_PRESENT) begin
        widePinOe_b <= 8'hff;
      end else if (slaveMode_d()) begin
        widePinOe_b <= readActive ? 8'h00 : 8'hff;
      end else begin
        widePinOe_b <= wideDir_d;
      end
      ctrlPinOut <= ctrlPins_d;
      ctrlPinOe_b <= PORTS_PRESENT ? ctrlDir_d[2:0] : 3'h7;
    end
  end

  // Slave mode as it will stand after this edge.
  function automatic logic slaveMode_d();
    return ctrlDir_d[SLAVE_SEL_BIT];
  endfunction

  // General-purpose read view: input pins show the pin level, output pins show the latch.
  function automatic logic [7:0] gpioView(input logic [7:0] pins, input logic [7:0] latch, input logic [7:0] dir);
    return (pins & dir) | (latch & ~dir);
  endfunction

  // Checks of the main behaviours.
  AST_WIDE_DIR_RESET: assert property (@(posedge core_clk) $rose(rst_b) |-> wideDir_q == WIDE_DIR_RESET)
    else $error("Wide direction not all ones after reset.");
  AST_CTRL_DIR_BIT3: assert property (@(posedge core_clk) disable iff (!rst_b) ctrlDir_q[3] == 1'b0)
    else $error("Control direction bit 3 set.");
  AST_ANALOG_ZERO: assert property (@(posedge core_clk) disable iff (!rst_b)
    rdTake && reqIdx == IDX_CTRL_PINS && analogSel_q == 3'h7 && !wrPend_q |=> hrdata == 32'h0)
    else $error("Analog control pin read nonzero.");
  AST_SLAVE_DRIVE: assert property (@(posedge core_clk) disable iff (!rst_b)
    readActive && slaveMode_d() && PORTS_PRESENT |=> widePinOe_b == 8'h00)
    else $error("Slave read did not drive the data pins.");
  AST_SLAVE_LATCH: assert property (@(posedge core_clk) disable iff (!rst_b)
    extWrite |=> widePins_q == $past(wideSync))
    else $error("Slave write did not latch the pins.");
  AST_GPIO_DIR: assert property (@(posedge core_clk) disable iff (!rst_b)
    !slaveMode && !$past(slaveMode) && PORTS_PRESENT |-> ##0 1'b1 ##1 (slaveMode || widePinOe_b == $past(wideDir_d)))
    else $error("Wide enables do not follow direction.");
  AST_CTRL_DIR: assert property (@(posedge core_clk) disable iff (!rst_b)
    PORTS_PRESENT |=> ctrlPinOe_b == $past(ctrlDir_d[2:0]))
    else $error("Control enables do not follow direction.");
  AST_ABSENT_ZERO: assert property (@(posedge core_clk) disable iff (!rst_b)
    !PORTS_PRESENT && rdTake |=> hrdata == 32'h0)
    else $error("Absent port read nonzero.");
  AST_NO_WAIT: assert property (@(posedge core_clk) disable iff (!rst_b) hreadyout && !hresp)
    else $error("Slave inserted a wait or error.");

  // Register reads carry one byte in the low bits.
  AST_READ_UPPER_ZERO: assert property (@(posedge core_clk) disable iff (!rst_b)
    rdTake |=> hrdata[31:8] == 24'h0)
    else $error("Read data has upper bits set.");
  // Control pin reads carry only three bits.
  AST_CTRL_PINS_WIDTH: assert property (@(posedge core_clk) disable iff (!rst_b)
    rdTake && reqIdx == IDX_CTRL_PINS |=> hrdata[31:3] == 29'h0)
    else $error("Control pin read too wide.");
  // Every analog control pin reads zero, whatever its level.
  AST_ANALOG_MASK: assert property (@(posedge core_clk) disable iff (!rst_b)
    rdTake && reqIdx == IDX_CTRL_PINS && !wrPend_q |=> (hrdata[2:0] & $past(analogSel_q)) == 3'h0)
    else $error("Analog control pin read nonzero.");
  // Unimplemented and flag bits of the control direction register read zero.
  AST_CTRL_DIR_READ: assert property (@(posedge core_clk) disable iff (!rst_b)
    rdTake && reqIdx == IDX_CTRL_DIR && !wrPend_q |=> hrdata[3] == 1'b0 && hrdata[7:5] == 3'h0)
    else $error("Control direction reserved bits read nonzero.");
  // Flag bits keep their reset value since no flag logic sets them.
  AST_CTRL_UPPER: assert property (@(posedge core_clk) disable iff (!rst_b)
    ctrlDir_q[7:5] == 3'h0)
    else $error("Control direction flag bits set.");
  // A direction write lands in the direction register.
  AST_DIR_WRITE: assert property (@(posedge core_clk) disable iff (!rst_b)
    wrPend_q && wrIdx_q == IDX_WIDE_DIR && PORTS_PRESENT |=> wideDir_q == $past(hwdata[7:0]))
    else $error("Wide direction write lost.");
  // The slave mode bit follows its write.
  AST_MODE_WRITE: assert property (@(posedge core_clk) disable iff (!rst_b)
    wrPend_q && wrIdx_q == IDX_CTRL_DIR && PORTS_PRESENT |=> slaveMode == $past(hwdata[SLAVE_SEL_BIT]))
    else $error("Slave mode write lost.");
  // Strobes have no effect outside slave mode.
  AST_STROBES_IDLE: assert property (@(posedge core_clk) disable iff (!rst_b)
    !slaveMode |-> !selActive && !extWrite)
    else $error("Strobe acted outside slave mode.");
  // In slave mode the data pins float unless a selected read is under way.
  AST_SLAVE_RELEASE: assert property (@(posedge core_clk) disable iff (!rst_b)
    PORTS_PRESENT && slaveMode_d() && !readActive |=> widePinOe_b == 8'hff)
    else $error("Slave port drove without a read.");
  // A selected read shows the data register on the pins.
  AST_SLAVE_DATA: assert property (@(posedge core_clk) disable iff (!rst_b)
    PORTS_PRESENT && slaveMode_d() && readActive |=> widePinOut == $past(widePins_d))
    else $error("Slave read drove the wrong byte.");
  // One write strobe latches once.
  AST_ONE_LATCH: assert property (@(posedge core_clk) disable iff (!rst_b)
    extWrite |=> !extWrite)
    else $error("Slave write latched twice.");
  // Outside slave mode only the bus changes the data register.
  AST_NO_GPIO_LATCH: assert property (@(posedge core_clk) disable iff (!rst_b)
    !slaveMode && !wrPend_q |=> widePins_q == $past(widePins_q))
    else $error("Data register changed without a write.");
  // General-purpose reads show pins for inputs and the latch for outputs.
  AST_GPIO_READ: assert property (@(posedge core_clk) disable iff (!rst_b)
    rdTake && reqIdx == IDX_WIDE_PINS && !wrPend_q && !slaveMode && PORTS_PRESENT
    |=> hrdata[7:0] == gpioView($past(wideSync), $past(widePins_q), $past(wideDir_q)))
    else $error("Wide pin read wrong.");
  // Absent ports never drive their pins.
  AST_ABSENT_FLOAT: assert property (@(posedge core_clk) disable iff (!rst_b)
    !PORTS_PRESENT |-> widePinOe_b == 8'hff && ctrlPinOe_b == 3'h7)
    else $error("Absent port drove a pin.");
  // Control pins come out of reset as analog inputs.
  AST_ANALOG_RESET: assert property (@(posedge core_clk) $rose(rst_b) |-> analogSel_q == ANALOG_RESET)
    else $error("Control pins not analog after reset.");
  // The control direction register comes out of reset at its documented value.
  AST_CTRL_RESET: assert property (@(posedge core_clk) $rose(rst_b) |-> ctrlDir_q == CTRL_DIR_RESET)
    else $error("Control direction wrong after reset.");
  // Direction bits keep steering analog pins.
  AST_ANALOG_DIR: assert property (@(posedge core_clk) disable iff (!rst_b)
    PORTS_PRESENT && analogSel_q != 3'h0 |=> ctrlPinOe_b == $past(ctrlDir_d[2:0]))
    else $error("Analog pin direction not followed.");
  COV_SLAVE_READ: cover property (@(posedge core_clk) disable iff (!rst_b) readActive);
  COV_SLAVE_WRITE: cover property (@(posedge core_clk) disable iff (!rst_b) extWrite);
  COV_MODE_SET: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(slaveMode));
  COV_BUS_READ: cover property (@(posedge core_clk) disable iff (!rst_b) rdTake);
  COV_ANALOG_READ: cover property (@(posedge core_clk) disable iff (!rst_b)
    rdTake && reqIdx == IDX_CTRL_PINS && analogSel_q == 3'h7);
endmodule
`default_nettype wire

// File: logic/wide_port_pkg.sv
// Constants shared by the wide port block: register offsets, field positions and reset values.
// Assumes an AHB-Lite slave with 32-bit data, one register per aligned word.
package wide_port_pkg;
  // Printed offsets are not all multiples of four, so they are word indices.
  localparam logic [7:0] IDX_WIDE_PINS = 8'h08;
  localparam logic [7:0] IDX_WIDE_DIR = 8'h88;
  localparam logic [7:0] IDX_CTRL_DIR = 8'h89;
  localparam logic [7:0] IDX_CTRL_PINS = 8'h09;
  localparam logic [7:0] IDX_ANALOG_CFG = 8'h9f;
  localparam logic [7:0] WIDE_DIR_RESET = 8'hff;
  localparam logic [7:0] CTRL_DIR_RESET = 8'h07;
  localparam logic [7:0] CTRL_DIR_MASK = 8'hf7;
  localparam logic [2:0] ANALOG_RESET = 3'h7;
  localparam logic [7:0] WIDE_PINS_RESET = 8'h00;
  localparam int SLAVE_SEL_BIT = 4;
  localparam int STB_READ = 0;
  localparam int STB_WRITE = 1;
  localparam int STB_SELECT = 2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // Converts a register index to its byte address.
  function automatic logic [9:0] regAddr(input logic [7:0] idx);
    return {idx, 2'h0};
  endfunction
endpackage

// File: logic/pin_sync.sv
// Two-flop synchroniser for a bus of pin inputs.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 8
) (
  input wire logic core_clk, // Core clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic [W-1:0] pinIn, // Raw pin levels.
  output logic [W-1:0] pinSync // Synchronised levels.
);
  logic [W-1:0] stage1_q;
  // First flop feeds only the second.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_q <= '0;
      pinSync <= '0;
    end else begin
      stage1_q <= pinIn;
      pinSync <= stage1_q;
    end
  end
endmodule
`default_nettype wire

// File: test/ext_cpu.sv
// External processor model that masters the parallel slave port.
// Assumes the bench resolves shared wires from all enables.
`timescale 1ns/10ps
`default_nettype none
module ext_cpu (
  input wire logic core_clk, // Pacing clock.
  input wire logic [7:0] dataIn, // Resolved data wires.
  output logic [7:0] dataOut, // Data put on undriven wires.
  output logic [2:0] stb // Read, write, select; active low.
);
  // Strobes idle high; released data starts at a5, and after a write shows the inverse of the byte written.
  initial begin
    stb = 3'h7;
    dataOut = 8'ha5;
  end
  // Read and select low, then take the byte once the port drives.
  task automatic readByte(output logic [7:0] d);
    stb <= 3'h2;
    repeat (4) @(posedge core_clk);
    d = dataIn;
    stb <= 3'h7;
    repeat (4) @(posedge core_clk);
  endtask
  // Data settles before write and select fall, and holds after they rise.
  task automatic writeByte(input logic [7:0] d);
    dataOut <= d;
    repeat (3) @(posedge core_clk);
    stb <= 3'h1;
    repeat (4) @(posedge core_clk);
    stb <= 3'h7;
    repeat (3) @(posedge core_clk);
    dataOut <= ~d;
    repeat (3) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// File: test/wide_port_tb.sv
// Self-checking bench for the wide port with an external processor model.
// Assumes the slave answers every transfer with hreadyout high.
`timescale 1ns/10ps
`default_nettype none
module wide_port_tb;
  import wide_port_pkg::*;
  logic core_clk, rst_b, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, hrdata2, x, r, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, cOut, cOe_b, cPin, stb;
  logic [7:0] wOut, wOe_b, wPin, cpuOut, v;
  int numErrors, checkCount;
  int cyc = 0;
  // Each wire carries the design's drive where enabled, else the far side's.
  assign wPin = (~wOe_b & wOut) | (wOe_b & cpuOut);
  assign cPin = (~cOe_b & cOut) | (cOe_b & stb);
  wide_port dut (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .widePinIn(wPin), .widePinOut(wOut), .widePinOe_b(wOe_b),
    .ctrlPinIn(cPin), .ctrlPinOut(cOut), .ctrlPinOe_b(cOe_b));
  // A variant without the ports shares the bus and must read zero.
  wide_port #(.PORTS_PRESENT(1'b0)) dut2 (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata2),
    .hreadyout(), .hresp(), .widePinIn(8'h00), .widePinOut(), .widePinOe_b(), .ctrlPinIn(3'h0),
    .ctrlPinOut(), .ctrlPinOe_b());
  ext_cpu cpu (.core_clk(core_clk), .dataIn(wPin), .dataOut(cpuOut), .stb(stb));
  // Clock at 10 MHz.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // A hang ends the run as a mismatch.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      numErrors = numErrors + 1;
      end_sim();
    end
  end
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("Errors %0d in %0d checks", numErrors, checkCount);
    if (numErrors == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One single word transfer, entered just after a clock edge.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    if (!w) begin
      chk(hrdata2, 32'h0);
    end
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  // Reset, register defaults, then port directions, analog reads and slave transfers.
  initial begin
    x = 32'd62835;
    {rst_b, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rdchk(IDX_WIDE_DIR, 32'hff);
    rdchk(IDX_CTRL_DIR, 32'h07);
    rdchk(IDX_CTRL_PINS, 32'h0);
    repeat (6) begin
      r = rnd();
      bus(1'b1, IDX_WIDE_DIR, {24'h0, r[7:0]});
      bus(1'b1, IDX_WIDE_PINS, {24'h0, r[15:8]});
      repeat (3) @(posedge core_clk);
      chk({24'h0, wOe_b}, {24'h0, r[7:0]});
      chk({24'h0, wOut & ~r[7:0]}, {24'h0, r[15:8] & ~r[7:0]});
      rdchk(IDX_WIDE_PINS, {24'h0, (r[15:8] & ~r[7:0]) | (wPin & r[7:0])});
    end
    r = rnd();
    bus(1'b1, IDX_ANALOG_CFG, 32'h0);
    bus(1'b1, IDX_CTRL_DIR, 32'h0);
    bus(1'b1, IDX_CTRL_PINS, {29'h0, r[2:0]});
    repeat (3) @(posedge core_clk);
    chk({29'h0, cOe_b}, 32'h0);
    rdchk(IDX_CTRL_PINS, {29'h0, r[2:0]});
    bus(1'b1, IDX_ANALOG_CFG, 32'h7);
    rdchk(IDX_CTRL_PINS, 32'h0);
    chk({29'h0, cOe_b}, 32'h0);
    bus(1'b1, IDX_CTRL_DIR, 32'hff);
    rdchk(IDX_CTRL_DIR, 32'h17);
    bus(1'b1, IDX_ANALOG_CFG, 32'h0);
    repeat (3) begin
      r = rnd();
      bus(1'b1, IDX_WIDE_PINS, {24'h0, r[7:0]});
      cpu.readByte(v);
      chk({24'h0, v}, {24'h0, r[7:0]});
      cpu.writeByte(r[15:8]);
      rdchk(IDX_WIDE_PINS, {24'h0, r[15:8]});
    end
    end_sim();
  end
endmodule
`default_nettype wire
